// ==== lic_pkg.sv ====
/*
   constants for the line interface control register block: register
   indices, field positions, reset values and timing figures.
   assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
package lic_pkg;

   // register indices as printed, byte address is four times the index
   localparam logic [7:0] LIC_IDX_CTRL5  = 8'h1F;
   localparam logic [7:0] LIC_IDX_GSTART = 8'h20;
   localparam logic [7:0] LIC_IDX_IRQSTA = 8'h21;
   localparam logic [7:0] LIC_IDX_IRQMSK = 8'h22;
   localparam logic [7:0] LIC_IDX_AUX    = 8'h23;
   localparam logic [7:0] LIC_IDX_LVSTAT = 8'h24;

   // first control register fields
   localparam int LIC_C5_FULL  = 7;
   localparam int LIC_C5_FOH   = 5;
   localparam int LIC_C5_EXT   = 3;
   localparam int LIC_C5_RX_HIGHPASS_SELECT  = 1;
   localparam int LIC_C5_LINE_VOLT_ZERO_FORCE_DISABLE  = 0;
   localparam logic [7:0] LIC_C5_RESET  = 8'h20;
   localparam logic [7:0] LIC_C5_WMASK  = 8'hEB;

   // ground start register fields
   localparam int LIC_GS_TGD  = 2;
   localparam int LIC_GS_TIP  = 1;
   localparam int LIC_GS_RING = 0;
   localparam logic [7:0] LIC_GS_RESET = 8'h00;
   localparam logic [7:0] LIC_GS_WMASK = 8'h03;

   // auxiliary control fields
   localparam int LIC_AUX_OH   = 0;
   localparam int LIC_AUX_OHS  = 1;
   localparam int LIC_AUX_SQ   = 2;
   localparam int LIC_AUX_DCV  = 4;
   localparam int LIC_AUX_MINI = 6;
   localparam logic [7:0] LIC_AUX_RESET = 8'h00;

   // interrupt status bits
   localparam int LIC_IRQ_SEIZED  = 0;
   localparam int LIC_IRQ_RELEASE = 1;
   localparam int LIC_IRQ_POLREV  = 2;
   localparam int LIC_IRQ_TIPGND  = 3;
   localparam int LIC_IRQ_W       = 4;

   // timing: one tick every 100 us
   localparam int    LIC_CLK_HZ      = 40_000_000;
   localparam int    LIC_TICK_US     = 100;
   localparam int    LIC_TICK_CYC    = LIC_CLK_HZ / 1_000_000 * LIC_TICK_US;
   localparam int    LIC_TICKS_PER_MS = 1000 / LIC_TICK_US;
   localparam int    LIC_OH_512_MS   = 512;
   localparam int    LIC_OH_128_MS   = 128;
   localparam int    LIC_OH_64_MS    = 64;
   localparam int    LIC_OH_8_MS     = 8;
   localparam int    LIC_REL_FAST_TK = 1;
   localparam int    LIC_REL_3_MS    = 3;
   localparam int    LIC_REL_26_MS   = 26;
   localparam int    LIC_LV_FORCE_V  = 3;
   localparam int    LIC_TMR_W       = 13;

   typedef enum logic [1:0] {
      LIC_ST_IDLE    = 2'b00,
      LIC_ST_SEIZING = 2'b01,
      LIC_ST_SEIZED  = 2'b11,
      LIC_ST_RELEASE = 2'b10
   } lic_hook_state_t;

endpackage

// ==== lic_hook_if.sv ====
/*
   interface between the register block and its hook timer.
   assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface lic_hook_if;
   import lic_pkg::*;
   logic                 offhookReq;
   logic [1:0]           offhookDelaySel;
   logic [LIC_TMR_W-1:0] releaseTicks;
   logic                 tick;
   logic                 loopClosed;
   logic                 seizeDone;
   logic                 releaseDone;
   modport ctrl  (output offhookReq, output offhookDelaySel, output releaseTicks, output tick,
                  input loopClosed, input seizeDone, input releaseDone);
   modport timer (input offhookReq, input offhookDelaySel, input releaseTicks, input tick,
                  output loopClosed, output seizeDone, output releaseDone);
endinterface

// ==== lic_hook_timer.sv ====
/*
   hook timer: runs the off-hook counter and the on-hook release delay.
   assumes a tick pulse every 100 us from the register block.
*/
`timescale 1ns/1ps
module lic_hook_timer
   import lic_pkg::*;
(
   // clock and synchronised reset
   input  wire logic    clk,
   input  wire logic    rstSyncN,
   // link to the register block
   lic_hook_if.timer    hook
);

   lic_hook_state_t      state_ff;
   logic [LIC_TMR_W-1:0] count_ff;
   logic                 seizeDone_ff;
   logic                 releaseDone_ff;

   // off-hook counter length in ticks
   function automatic logic [LIC_TMR_W-1:0] seizeTicks(input logic [1:0] sel);
      unique case (sel)
         2'b00: seizeTicks = LIC_TMR_W'(LIC_OH_512_MS * LIC_TICKS_PER_MS);
         2'b01: seizeTicks = LIC_TMR_W'(LIC_OH_128_MS * LIC_TICKS_PER_MS);
         2'b10: seizeTicks = LIC_TMR_W'(LIC_OH_64_MS * LIC_TICKS_PER_MS);
         2'b11: seizeTicks = LIC_TMR_W'(LIC_OH_8_MS * LIC_TICKS_PER_MS);
      endcase
   endfunction

   // sequence: counter runs on request, release timed from request clear
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_ff       <= LIC_ST_IDLE;
         count_ff       <= '0;
         seizeDone_ff   <= 1'b0;
         releaseDone_ff <= 1'b0;
      end else begin
         seizeDone_ff   <= 1'b0;
         releaseDone_ff <= 1'b0;
         unique case (state_ff)
            LIC_ST_IDLE: begin
               if (hook.offhookReq) begin
                  state_ff <= LIC_ST_SEIZING;
                  count_ff <= seizeTicks(hook.offhookDelaySel);
               end
            end
            LIC_ST_SEIZING: begin
               if (!hook.offhookReq) begin
                  state_ff <= LIC_ST_RELEASE;
                  count_ff <= hook.releaseTicks;
               end else if (hook.tick) begin
                  if (count_ff <= LIC_TMR_W'(1)) begin
                     state_ff     <= LIC_ST_SEIZED;
                     seizeDone_ff <= 1'b1;
                  end
                  count_ff <= count_ff - LIC_TMR_W'(1);
               end
            end
            LIC_ST_SEIZED: begin
               if (!hook.offhookReq) begin
                  state_ff <= LIC_ST_RELEASE;
                  count_ff <= hook.releaseTicks;
               end
            end
            LIC_ST_RELEASE: begin
               // loop current held until the release delay runs out
               if (hook.tick) begin
                  if (count_ff <= LIC_TMR_W'(1)) begin
                     state_ff       <= LIC_ST_IDLE;
                     releaseDone_ff <= 1'b1;
                  end
                  count_ff <= count_ff - LIC_TMR_W'(1);
               end
            end
         endcase
      end
   end

   assign hook.loopClosed  = (state_ff != LIC_ST_IDLE);
   assign hook.seizeDone   = seizeDone_ff;
   assign hook.releaseDone = releaseDone_ff;

endmodule

// ==== lic_regs.sv ====
/*
   line interface control registers behind an APB slave: full-scale and
   filter controls, off-hook and release timing, line voltage status with
   low-voltage forcing, ground start relays and tip ground flag, plus an
   interrupt status and mask pair.
   assumes synchronous analog inputs and a 40 MHz clock; rstn is async.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module lic_regs
   import lic_pkg::*;
#(
   parameter int TICK_CYC = LIC_TICK_CYC
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // line side inputs
   input  wire logic [7:0]  lineVoltRaw,
   input  wire logic        tipCurrentFlow,
   // line side controls
   output      logic        fullScaleEn,
   output      logic        rxHighpassSel,
   output      logic        loopClosed,
   output      logic [1:0]  dcTerminationVoltage,
   output      logic [1:0]  minLoopCurrentSel,
   output      logic        tipRelayOpen,
   output      logic        ringRelayOpen,
   // interrupt
   output      logic        irq
);

   // reset release through two flops
   logic rstMeta_ff;
   logic rstSyncN;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_ff <= 1'b0;
         rstSyncN   <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSyncN   <= rstMeta_ff;
      end
   end

   // registers
   logic [7:0]           ctrl5_ff;
   logic [7:0]           gstart_ff;
   logic [7:0]           aux_ff;
   logic [LIC_IRQ_W-1:0] irqSta_ff;
   logic [LIC_IRQ_W-1:0] irqMsk_ff;
   logic [7:0]           lvStat_ff;
   logic                 tipFlag_ff;
   logic [31:0]          rdData_ff;
   logic [LIC_IRQ_W-1:0] rdSnap_ff;
   logic [15:0]          tickCnt_ff;
   logic                 tick_ff;

   // bus decode
   logic       setupPh;
   logic       accessPh;
   logic       wrEn;
   logic       rdEn;
   logic [7:0] regIdx;
   logic       addrHit;

   lic_hook_if hook ();

   assign regIdx   = paddr[9:2];
   assign setupPh  = psel && !penable;
   assign accessPh = psel && penable;
   // unmapped addresses answer with an error and have no effect
   assign addrHit  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                     ((regIdx == LIC_IDX_CTRL5)  || (regIdx == LIC_IDX_GSTART) ||
                      (regIdx == LIC_IDX_IRQSTA) || (regIdx == LIC_IDX_IRQMSK) ||
                      (regIdx == LIC_IDX_AUX)    || (regIdx == LIC_IDX_LVSTAT));
   assign wrEn     = accessPh && pwrite && addrHit;
   assign rdEn     = accessPh && !pwrite && addrHit;
   assign pready   = 1'b1;
   assign pslverr  = accessPh && !addrHit;
   assign prdata   = rdData_ff;

   // force a reading at or below the threshold to zero
   function automatic logic [7:0] lineVoltView(input logic [7:0] raw, input logic noForce);
      logic [7:0] mag;
      mag = raw[7] ? (8'h00 - raw) : raw;
      if (!noForce && (mag <= 8'(LIC_LV_FORCE_V)))
         lineVoltView = 8'h00;
      else
         lineVoltView = raw;
   endfunction

   // release delay in ticks from speed bits
   function automatic logic [LIC_TMR_W-1:0] releaseTicks(input logic base, input logic ext,
                                                         input logic [1:0] sq);
      if (base && (sq == 2'b11))
         releaseTicks = LIC_TMR_W'(LIC_REL_26_MS * LIC_TICKS_PER_MS);
      else if (base || ext)
         releaseTicks = LIC_TMR_W'(LIC_REL_3_MS * LIC_TICKS_PER_MS);
      else
         releaseTicks = LIC_TMR_W'(LIC_REL_FAST_TK);
   endfunction

   // first control register; reserved bits 4 and 2 are not stored
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN)
         ctrl5_ff <= LIC_C5_RESET;
      else if (wrEn && (regIdx == LIC_IDX_CTRL5))
         ctrl5_ff <= pwdata[7:0] & LIC_C5_WMASK;
   end

   // ground start register, relay bits only
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN)
         gstart_ff <= LIC_GS_RESET;
      else if (wrEn && (regIdx == LIC_IDX_GSTART))
         gstart_ff <= pwdata[7:0] & LIC_GS_WMASK;
   end

   // auxiliary hook and termination controls
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN)
         aux_ff <= LIC_AUX_RESET;
      else if (wrEn && (regIdx == LIC_IDX_AUX))
         aux_ff <= pwdata[7:0];
   end

   // interrupt mask
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN)
         irqMsk_ff <= '0;
      else if (wrEn && (regIdx == LIC_IDX_IRQMSK))
         irqMsk_ff <= pwdata[LIC_IRQ_W-1:0];
   end

   // 100 us tick divider for the hook timer
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         tickCnt_ff <= '0;
         tick_ff    <= 1'b0;
      end else if (tickCnt_ff == 16'(TICK_CYC - 1)) begin
         tickCnt_ff <= '0;
         tick_ff    <= 1'b1;
      end else begin
         tickCnt_ff <= tickCnt_ff + 16'h0001;
         tick_ff    <= 1'b0;
      end
   end

   // line voltage status follows the sensed voltage every cycle
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN)
         lvStat_ff <= 8'h00;
      else
         lvStat_ff <= lineVoltView(lineVoltRaw, ctrl5_ff[LIC_C5_LINE_VOLT_ZERO_FORCE_DISABLE]);
   end

   // tip ground flag; an open tip relay cannot sense grounding so it reads one
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN)
         tipFlag_ff <= 1'b1;
      else
         tipFlag_ff <= !(tipCurrentFlow && !gstart_ff[LIC_GS_TIP]);
   end

   // events
   logic [LIC_IRQ_W-1:0] irqEvt;
   logic [7:0]           lvNext;

   assign lvNext = lineVoltView(lineVoltRaw, ctrl5_ff[LIC_C5_LINE_VOLT_ZERO_FORCE_DISABLE]);
   always_comb begin
      irqEvt                  = '0;
      irqEvt[LIC_IRQ_SEIZED]  = hook.seizeDone;
      irqEvt[LIC_IRQ_RELEASE] = hook.releaseDone;
      irqEvt[LIC_IRQ_POLREV]  = (lvNext[7] != lvStat_ff[7]);
      irqEvt[LIC_IRQ_TIPGND]  = tipFlag_ff && !tipCurrentFlow ? 1'b0 :
                                (tipFlag_ff && tipCurrentFlow && !gstart_ff[LIC_GS_TIP]);
   end

   // sticky status; a read clears only the bits it returned, new events win
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN)
         irqSta_ff <= '0;
      else if (rdEn && (regIdx == LIC_IDX_IRQSTA))
         irqSta_ff <= (irqSta_ff & ~rdSnap_ff) | irqEvt;
      else
         irqSta_ff <= irqSta_ff | irqEvt;
   end

   assign irq = |(irqSta_ff & irqMsk_ff);

   // read data captured in the setup phase so prdata comes from a flop
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         rdData_ff <= 32'h0000_0000;
         rdSnap_ff <= '0;
      end else if (setupPh && !pwrite) begin
         rdSnap_ff <= '0;
         unique case (paddr[9:2])
            LIC_IDX_CTRL5:  rdData_ff <= {24'h000000, ctrl5_ff};
            LIC_IDX_GSTART: rdData_ff <= {24'h000000, 5'h00, tipFlag_ff, gstart_ff[1:0]};
            LIC_IDX_IRQSTA: begin
               rdData_ff <= {28'h0000000, irqSta_ff};
               rdSnap_ff <= irqSta_ff;
            end
            LIC_IDX_IRQMSK: rdData_ff <= {28'h0000000, irqMsk_ff};
            LIC_IDX_AUX:    rdData_ff <= {24'h000000, aux_ff};
            LIC_IDX_LVSTAT: rdData_ff <= {24'h000000, lvStat_ff};
            default:        rdData_ff <= 32'h0000_0000;
         endcase
      end
   end

   // hook timer hookup
   assign hook.offhookReq      = aux_ff[LIC_AUX_OH];
   assign hook.offhookDelaySel = ctrl5_ff[LIC_C5_FOH +: 2];
   assign hook.releaseTicks    = releaseTicks(aux_ff[LIC_AUX_OHS], ctrl5_ff[LIC_C5_EXT],
                                              aux_ff[LIC_AUX_SQ +: 2]);
   assign hook.tick            = tick_ff;

   lic_hook_timer u_timer (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .hook     (hook.timer)
   );

   // line side controls straight from the registers, loop state from the hook timer
   assign fullScaleEn          = ctrl5_ff[LIC_C5_FULL];
   assign rxHighpassSel        = ctrl5_ff[LIC_C5_RX_HIGHPASS_SELECT];
   assign tipRelayOpen         = gstart_ff[LIC_GS_TIP];
   assign ringRelayOpen        = gstart_ff[LIC_GS_RING];
   assign loopClosed           = hook.loopClosed;
   assign dcTerminationVoltage = aux_ff[LIC_AUX_DCV +: 2];
   assign minLoopCurrentSel    = aux_ff[LIC_AUX_MINI +: 2];

endmodule

// ==== lic_regs_chk.sv ====
/*
   checker for the line interface control registers: control outputs
   against apb writes, reserved and mirrored bits on reads.
   assumes it is bound to lic_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module lic_regs_chk
   import lic_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // line side
   input wire logic [7:0]  lineVoltRaw,
   input wire logic        tipCurrentFlow,
   input wire logic        fullScaleEn,
   input wire logic        rxHighpassSel,
   input wire logic        loopClosed,
   input wire logic [1:0]  dcTerminationVoltage,
   input wire logic [1:0]  minLoopCurrentSel,
   input wire logic        tipRelayOpen,
   input wire logic        ringRelayOpen,
   input wire logic        irq
);
   localparam logic [11:0] A_C5  = {2'b00, LIC_IDX_CTRL5, 2'b00};
   localparam logic [11:0] A_GS  = {2'b00, LIC_IDX_GSTART, 2'b00};
   localparam logic [11:0] A_AUX = {2'b00, LIC_IDX_AUX, 2'b00};
   logic wrEnd;
   logic rdSetup;

   // completed write and read setup cycle, the address is checked per rule
   assign wrEnd   = psel && penable && pwrite && pready;
   assign rdSetup = psel && !penable && !pwrite;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   full_scale_a: assert property (wrEnd && paddr == A_C5 |=> fullScaleEn == $past(pwdata[7]))
      else $error("full scale output does not follow write");
   highpass_sel_a: assert property (wrEnd && paddr == A_C5 |=> rxHighpassSel == $past(pwdata[1]))
      else $error("highpass select does not follow write");
   tip_relay_a: assert property (wrEnd && paddr == A_GS |=> tipRelayOpen == $past(pwdata[1]))
      else $error("tip relay does not follow write");
   ring_relay_a: assert property (wrEnd && paddr == A_GS |=> ringRelayOpen == $past(pwdata[0]))
      else $error("ring relay does not follow write");
   relay_hold_a: assert property (!(wrEnd && paddr == A_GS) |=> $stable(tipRelayOpen) && $stable(ringRelayOpen))
      else $error("relay moved without a write");
   c5_reserved_a: assert property (rdSetup && paddr == A_C5 |=> prdata[4] == 1'b0 && prdata[2] == 1'b0)
      else $error("reserved control bits read nonzero");
   c5_mirror_a: assert property (rdSetup && paddr == A_C5 |=> prdata[7] == fullScaleEn && prdata[1] == rxHighpassSel)
      else $error("control read disagrees with outputs");
   gs_reserved_a: assert property (rdSetup && paddr == A_GS |=> prdata[31:3] == 29'h0 && prdata[1:0] == {tipRelayOpen, ringRelayOpen})
      else $error("ground start read wrong");
   // the flag lags the relay bit by one cycle, so both the old and new relay state must be open
   tip_flag_a: assert property (rdSetup && paddr == A_GS && tipRelayOpen && $past(tipRelayOpen) |=> prdata[2])
      else $error("tip flag low with relay open");
   loop_close_a: assert property (wrEnd && paddr == A_AUX && pwdata[0] |-> ##[1:2] loopClosed)
      else $error("loop did not close on off-hook request");
endmodule

// ==== line_interface_control_regs_tb_top.sv ====
/*
   testbench for the line interface control registers: register access,
   hook timing, line voltage forcing, relays and interrupt masking.
   assumes lic_regs with a shortened tick; apb answers are awaited.
*/
`timescale 1ns/1ps
module line_interface_control_regs_tb_top;
   import lic_pkg::*;
   localparam int TK = 8; // short tick keeps the longest off-hook count affordable
   logic        clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  lineVoltRaw;
   logic        tipCurrentFlow;
   logic        fullScaleEn;
   logic        rxHighpassSel;
   logic        loopClosed;
   logic [1:0]  dcTerminationVoltage;
   logic [1:0]  minLoopCurrentSel;
   logic        tipRelayOpen;
   logic        ringRelayOpen;
   logic        irq;
   logic [31:0] v;
   logic        e;
   int          n_mismatch;
   int          cmp_count;
   int          n;
   logic [7:0]  lvIn [6]  = '{8'h03, 8'hFD, 8'h04, 8'hFC, 8'h03, 8'h00};
   logic [7:0]  lvExp [6] = '{8'h00, 8'h00, 8'h04, 8'hFC, 8'h03, 8'h00};

   lic_regs #(.TICK_CYC(TK)) dut (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lineVoltRaw(lineVoltRaw),
      .tipCurrentFlow(tipCurrentFlow), .fullScaleEn(fullScaleEn), .rxHighpassSel(rxHighpassSel),
      .loopClosed(loopClosed), .dcTerminationVoltage(dcTerminationVoltage),
      .minLoopCurrentSel(minLoopCurrentSel), .tipRelayOpen(tipRelayOpen), .ringRelayOpen(ringRelayOpen),
      .irq(irq));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer; data and error are taken at the edge that sees pready
   task automatic apb(input logic isWr, input logic [7:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      psel    <= 1'b1;
      pwrite  <= isWr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      v = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (k >= 20) begin
         n_mismatch++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx);
      apb(1'b0, idx, 8'h00);
   endtask

   // inputs are level sampled, so give them a few cycles to reach the status
   task automatic settle();
      repeat (4) @(posedge clk);
   endtask

   // counts cycles until irq rises or the loop opens, bounded
   task automatic waitSig(input logic forIrq);
      n = 0;
      while ((forIrq ? irq !== 1'b1 : loopClosed !== 1'b0) && n < 60000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 60000) begin
         n_mismatch++;
         wrap_up();
      end
   endtask

   // seize then release the line; tick phase allows one tick either way
   task automatic hookRun(input logic [1:0] foh, input logic base, input logic ext, input logic [1:0] sq,
                          input int ohTk, input int relTk);
      wr(LIC_IDX_CTRL5, {1'b0, foh, 1'b0, ext, 3'b000});
      wr(LIC_IDX_AUX, {4'b0011, sq, base, 1'b1});
      waitSig(1'b1);
      check({31'h0, (n >= (ohTk - 1) * TK && n <= (ohTk + 1) * TK + 8)}, 32'h1);
      rd(LIC_IDX_IRQSTA);
      check(v, 32'h1);
      check({31'h0, irq}, 32'h0);
      wr(LIC_IDX_AUX, {4'b0011, sq, base, 1'b0});
      waitSig(1'b0);
      check({31'h0, (n >= (relTk - 1) * TK && n <= (relTk + 1) * TK + 8)}, 32'h1);
      check({31'h0, irq}, 32'h0);
      rd(LIC_IDX_IRQSTA);
      check(v, 32'h2);
   endtask

   // main sequence
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      lineVoltRaw = 8'h30;
      tipCurrentFlow = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(LIC_IDX_CTRL5);
      check(v, 32'h20);
      rd(LIC_IDX_GSTART);
      check(v, 32'h04);
      rd(LIC_IDX_AUX);
      check(v, 32'h00);
      wr(LIC_IDX_AUX, 8'hC0);
      check({30'h0, minLoopCurrentSel}, 32'h3);
      wr(LIC_IDX_AUX, 8'h30);
      check({30'h0, dcTerminationVoltage}, 32'h3);
      check({30'h0, minLoopCurrentSel}, 32'h0);
      rd(LIC_IDX_AUX);
      check(v, 32'h30);
      // software keeps reserved bits 4 and 2 at zero on every control write
      wr(LIC_IDX_CTRL5, 8'hEB);
      rd(LIC_IDX_CTRL5);
      check(v, 32'hEB);
      check({30'h0, fullScaleEn, rxHighpassSel}, 32'h3);
      wr(LIC_IDX_CTRL5, 8'h00);
      check({30'h0, fullScaleEn, rxHighpassSel}, 32'h0);
      wr(LIC_IDX_GSTART, 8'hFF);
      tipCurrentFlow <= 1'b1;
      settle();
      rd(LIC_IDX_GSTART);
      check(v, 32'h07);
      wr(LIC_IDX_GSTART, 8'h00);
      settle();
      rd(LIC_IDX_GSTART);
      check(v, 32'h00);
      tipCurrentFlow <= 1'b0;
      settle();
      rd(LIC_IDX_GSTART);
      check(v, 32'h04);
      rd(LIC_IDX_IRQSTA);
      check(v & 32'h8, 32'h8);
      rd(LIC_IDX_IRQSTA);
      check(v, 32'h0);
      apb(1'b1, 8'h30, 8'hFF);
      check({31'h0, e}, 32'h1);
      apb(1'b0, 8'h30, 8'h00);
      check({31'h0, e}, 32'h1);
      check(v, 32'h0);
      wr(LIC_IDX_IRQMSK, 8'h01);
      rd(LIC_IDX_IRQMSK);
      check(v, 32'h1);
      hookRun(2'b11, 1'b0, 1'b0, 2'b00, 80, 1);
      hookRun(2'b10, 1'b0, 1'b1, 2'b00, 640, 30);
      hookRun(2'b01, 1'b1, 1'b0, 2'b11, 1280, 260);
      hookRun(2'b00, 1'b1, 1'b1, 2'b11, 5120, 260);
      // forcing on for the first four entries, disabled for the last two
      for (int i = 0; i < 6; i++) begin
         if (i == 4)
            wr(LIC_IDX_CTRL5, 8'h01);
         lineVoltRaw <= lvIn[i];
         settle();
         rd(LIC_IDX_LVSTAT);
         check(v, {24'h0, lvExp[i]});
      end
      check({31'h0, irq}, 32'h0);
      rd(LIC_IDX_IRQSTA);
      check(v & 32'h4, 32'h4);
      wrap_up();
   end
endmodule

bind lic_regs lic_regs_chk chk (
   .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lineVoltRaw(lineVoltRaw),
   .tipCurrentFlow(tipCurrentFlow), .fullScaleEn(fullScaleEn), .rxHighpassSel(rxHighpassSel),
   .loopClosed(loopClosed), .dcTerminationVoltage(dcTerminationVoltage),
   .minLoopCurrentSel(minLoopCurrentSel), .tipRelayOpen(tipRelayOpen), .ringRelayOpen(ringRelayOpen),
   .irq(irq));
